/* design/sbg_glue.sv */
`timescale 1ns/1ps
`include "sbg_consts.svh"
// Summary of operation
// - memory and adapter selects need the valid-address strobe
// - cpu direction high is read, low is write
// - nmi input acts on a falling edge
// - irq input acts on a low level
// - ram select: top digit 0, second digit 0 or 1, qualified
// - adapter selects from second digits 2..7, qualified, top zero
// - prom enables from top digits 5,6,7 with bank groups
// - bank groups are inverted AND of four consecutive active-low digit decodes
// - talk bit lets transceivers send onto instrument bus
// - listen bit lets logic drive ndac and nrfd
// - acceptor ready governs nrfd
// - ready-for-data also governs nrfd
// - logic makes transceiver output enable
// - completion flag raised after common-bus transfer
// - interrupt line to adapter on scope strobe
// - read strobe captures common-bus data into latch
// - data gate enables data transceivers
// - address gate enables address buffers
// - clear resets all common-bus control flip-flops
// - adapter direction high reads, low writes common bus
// - rising start edge launches the transfer
// - answer grant with select-acknowledge before mastering
// - master only when sync-ack and bus-busy are idle
// - attention forces nrfd within 200 ns
module sbg_glue #(
    parameter int DATA_W = 16,
    parameter int ADDR_W = 13
) (
    // clock and reset
    input wire logic i_clock,
    input wire logic i_reset,
    // cpu side
    input wire logic [15:0] i_cpu_addr,
    input wire logic i_valid_address_strobe,
    input wire logic i_cpu_read_not_write,
    input wire logic i_nmi_source_n,
    input wire logic i_irq_source_n,
    output logic o_phase1,
    output logic o_phase2,
    output logic o_cpu_bus_drive_enable,
    output logic o_nmi_request,
    output logic o_irq_request,
    output logic o_ram_sel_n,
    output logic o_ram_write,
    output logic o_adapter_read,
    output logic [5:0] o_pia_sel_n,
    output logic [2:0] o_prom_sel_n,
    output logic [3:0] o_prom_bank_group_enables,
    // instrument bus handshake
    input wire logic i_talk,
    input wire logic i_listen,
    input wire logic i_rdy,
    input wire logic i_rfd,
    input wire logic i_atn_n,
    input wire logic i_dav_n,
    output logic o_out_enable,
    output logic o_nrfd_out,
    output logic o_nrfd_oe_n,
    output logic o_ndac_out,
    output logic o_ndac_oe_n,
    // adapter side of common-bus logic
    input wire logic i_clear,
    input wire logic i_host_read,
    input wire logic i_start,
    input wire logic [DATA_W-1:0] i_wr_data,
    input wire logic [ADDR_W-1:0] i_wr_addr,
    output logic o_done,
    output logic o_scope_interrupt_line,
    output logic [DATA_W-1:0] o_rd_data,
    // common bus
    input wire logic [DATA_W-1:0] i_bus_data_n,
    input wire logic i_io_strobe_n,
    input wire logic i_priority_grant_input,
    input wire logic i_sync_ack_n,
    input wire logic i_bus_busy,
    output logic o_channel_request_n,
    output logic o_select_ack_n,
    output logic o_read_data,
    output logic o_host_data_gate,
    output logic o_host_address_gate,
    output logic o_data_mode_n,
    output logic [DATA_W-1:0] o_bus_data_n,
    output logic [ADDR_W-1:0] o_bus_addr_n
);
    if (DATA_W != 16 || ADDR_W != 13) begin : g_bad_width
        $error("sbg_glue: bus widths fixed at 16 data, 13 address");
    end

    // ----------------------------------------
    // two-phase clock
    // ----------------------------------------
    logic [1:0] phase_cnt_q;
    logic [1:0] phase_cnt_d;
    assign phase_cnt_d = phase_cnt_q + 2'h1;
    always_ff @(posedge i_clock) begin
        if (i_reset) phase_cnt_q <= 2'h0;
        else phase_cnt_q <= phase_cnt_d;
    end
    wire phase2 = phase_cnt_q[1];
    assign o_phase1 = ~phase2;
    assign o_phase2 = phase2;
    assign o_cpu_bus_drive_enable = phase2;

    // ----------------------------------------
    // address decode
    // ----------------------------------------
    sbg_addr_decode u_dec (
        .i_addr(i_cpu_addr),
        .i_valid_address_strobe(i_valid_address_strobe),
        .i_phase2(phase2),
        .o_ram_sel_n(o_ram_sel_n),
        .o_pia_sel_n(o_pia_sel_n),
        .o_prom_sel_n(o_prom_sel_n),
        .o_prom_bank_group_enables(o_prom_bank_group_enables)
    );
    assign o_ram_write = ~o_ram_sel_n & ~i_cpu_read_not_write;
    assign o_adapter_read = ~(&o_pia_sel_n) & i_cpu_read_not_write;

    // ----------------------------------------
    // cpu interrupts
    // ----------------------------------------
    logic nmi_prev_q;
    logic nmi_req_q;
    wire nmi_fall = nmi_prev_q & ~i_nmi_source_n;
    always_ff @(posedge i_clock) begin
        if (i_reset) begin
            nmi_prev_q <= 1'b1;
            nmi_req_q <= 1'b0;
        end else begin
            nmi_prev_q <= i_nmi_source_n;
            nmi_req_q <= nmi_fall;
        end
    end
    assign o_nmi_request = nmi_req_q;
    assign o_irq_request = ~i_irq_source_n;

    // ----------------------------------------
    // instrument bus handshake
    // ----------------------------------------
    // attention is combinational: one path, well under the 200 ns bound
    wire atn = ~i_atn_n;
    wire nrfd_assert = atn | (i_listen & ~i_rdy)
                     | (i_talk & ~i_rfd);
    logic ndac_q;
    always_ff @(posedge i_clock) begin
        if (i_reset) ndac_q <= 1'b1;
        else if (i_dav_n) ndac_q <= 1'b1;
        else if (i_rdy) ndac_q <= 1'b0;
    end
    assign o_out_enable = i_talk & ~atn;
    assign o_nrfd_out = ~nrfd_assert;
    assign o_nrfd_oe_n = ~(i_listen | atn | i_talk);
    assign o_ndac_out = ~ndac_q;
    assign o_ndac_oe_n = ~i_listen;

    // ----------------------------------------
    // common-bus control
    // ----------------------------------------
    sbg_pkg::sbg_state_t state_q;
    sbg_pkg::sbg_state_t state_d;
    logic start_prev_q;
    logic scope_interrupt_line_q;
    logic strobe_prev_q;
    logic [DATA_W-1:0] rd_data_q;
    logic dir_q;
    wire start_rise = i_start & ~start_prev_q;
    wire sync_ack = ~i_sync_ack_n;
    wire strobe_fall = strobe_prev_q & ~i_io_strobe_n;

    always_comb begin
        state_d = state_q;
        case (state_q)
            sbg_pkg::SBG_IDLE: begin
                if (start_rise) state_d = sbg_pkg::SBG_REQ;
            end
            sbg_pkg::SBG_REQ: begin
                if (i_priority_grant_input) state_d = sbg_pkg::SBG_ACK;
            end
            sbg_pkg::SBG_ACK: begin
                // hold select-ack until the grant goes away and sync-ack and bus-busy are idle
                if (!i_priority_grant_input && !sync_ack && !i_bus_busy)
                    state_d = sbg_pkg::SBG_MASTER;
            end
            sbg_pkg::SBG_MASTER: begin
                state_d = sbg_pkg::SBG_WAIT_SYNC;
            end
            sbg_pkg::SBG_WAIT_SYNC: begin
                if (sync_ack) state_d = sbg_pkg::SBG_DONE;
            end
            sbg_pkg::SBG_DONE: begin
                state_d = sbg_pkg::SBG_DONE;
            end
            default: state_d = sbg_pkg::SBG_IDLE;
        endcase
    end

    always_ff @(posedge i_clock) begin
        if (i_reset || i_clear) begin
            state_q <= sbg_pkg::SBG_IDLE;
            start_prev_q <= 1'b1;
            scope_interrupt_line_q <= 1'b0;
            strobe_prev_q <= 1'b1;
            rd_data_q <= '0;
            dir_q <= 1'b1;
        end else begin
            state_q <= state_d;
            start_prev_q <= i_start;
            strobe_prev_q <= i_io_strobe_n;
            if (strobe_fall) scope_interrupt_line_q <= 1'b1;
            if (start_rise) dir_q <= i_host_read;
            if (o_read_data) rd_data_q <= ~i_bus_data_n;
        end
    end

    wire mastering = (state_q == sbg_pkg::SBG_MASTER) ||
                     (state_q == sbg_pkg::SBG_WAIT_SYNC);
    assign o_channel_request_n = ~(state_q == sbg_pkg::SBG_REQ);
    assign o_select_ack_n = ~(state_q == sbg_pkg::SBG_ACK);
    assign o_host_address_gate = mastering;
    assign o_host_data_gate = mastering & ~dir_q;
    assign o_read_data = (state_q == sbg_pkg::SBG_WAIT_SYNC) & dir_q
                       & sync_ack;
    assign o_data_mode_n = ~dir_q;
    assign o_done = (state_q == sbg_pkg::SBG_DONE);
    assign o_scope_interrupt_line = scope_interrupt_line_q;
    assign o_rd_data = rd_data_q;
    assign o_bus_data_n = mastering & ~dir_q ? ~i_wr_data
                        : {DATA_W{1'b1}};
    assign o_bus_addr_n = mastering ? ~i_wr_addr : {ADDR_W{1'b1}};
endmodule // sbg_glue

/* common/sbg_consts.svh */
`ifndef SBG_CONSTS_SVH
`define SBG_CONSTS_SVH
// ----------------------------------------
// address decode
// ----------------------------------------
`define SBG_TOP_MSB 14
`define SBG_TOP_LSB 12
`define SBG_SEC_MSB 11
`define SBG_SEC_LSB 8
`define SBG_TOP_RAM 3'h0
`define SBG_TOP_PROM_A 3'h5
`define SBG_TOP_PROM_B 3'h6
`define SBG_TOP_PROM_C 3'h7
`define SBG_RAM_SEC_LAST 4'h1
`define SBG_PIA_SEC_FIRST 4'h2
`define SBG_PIA_SEC_LAST 4'h7
// ----------------------------------------
// timing
// ----------------------------------------
`define SBG_CLK_PERIOD_NS 50
`define SBG_NRFD_MAX_NS 200
`define SBG_NRFD_MAX_CYC (`SBG_NRFD_MAX_NS / `SBG_CLK_PERIOD_NS)
`define SBG_PHASE_DIV 4
`endif

/* common/sbg_pkg.sv */
package sbg_pkg;
    typedef enum logic [2:0] {
        SBG_IDLE,
        SBG_REQ,
        SBG_ACK,
        SBG_MASTER,
        SBG_WAIT_SYNC,
        SBG_DONE
    } sbg_state_t;
endpackage

/* design/sbg_addr_decode.sv */
`timescale 1ns/1ps
`include "sbg_consts.svh"
module sbg_addr_decode (
    // cpu address and qualifiers
    input wire logic [15:0] i_addr,
    input wire logic i_valid_address_strobe,
    input wire logic i_phase2,
    // selects, active low; bank group enables active high
    output logic o_ram_sel_n,
    output logic [5:0] o_pia_sel_n,
    output logic [2:0] o_prom_sel_n,
    output logic [3:0] o_prom_bank_group_enables
);
    wire [2:0] top = i_addr[`SBG_TOP_MSB:`SBG_TOP_LSB];
    wire [3:0] sec = i_addr[`SBG_SEC_MSB:`SBG_SEC_LSB];
    wire [15:0] sec_dec_n = ~(16'h0001 << sec);
    wire qual = i_valid_address_strobe & i_phase2;
    wire top_zero = (top == `SBG_TOP_RAM);
    wire [2:0] top_prom = {top == `SBG_TOP_PROM_C,
                           top == `SBG_TOP_PROM_B,
                           top == `SBG_TOP_PROM_A};
    genvar g;
    // bank group k goes high when any of its four low decodes is active
    for (g = 0; g < 4; g++) begin : g_bank
        assign o_prom_bank_group_enables[g] =
            ~&sec_dec_n[g*4 +: 4];
    end
    assign o_ram_sel_n = ~(qual & top_zero &
        (sec <= `SBG_RAM_SEC_LAST));
    for (g = 0; g < 6; g++) begin : g_pia
        assign o_pia_sel_n[g] = ~(qual & top_zero &
            ~sec_dec_n[g + 2]);
    end
    assign o_prom_sel_n = ~({3{qual & (|o_prom_bank_group_enables)}}
        & top_prom);
endmodule // sbg_addr_decode

/* tb/sbg_glue_asserts.sv */
`timescale 1ns/1ps
module sbg_glue_asserts (
    // inputs of the glue
    input wire logic i_clock, i_reset, i_valid_address_strobe,
    input wire logic [15:0] i_cpu_addr,
    input wire logic i_nmi_source_n, i_irq_source_n, i_talk, i_atn_n,
    input wire logic i_clear, i_sync_ack_n, i_bus_busy,
    // outputs of the glue
    input wire logic o_phase2, o_ram_sel_n, o_nmi_request, o_irq_request,
    input wire logic [5:0] o_pia_sel_n,
    input wire logic [3:0] o_prom_bank_group_enables,
    input wire logic o_out_enable, o_nrfd_out, o_nrfd_oe_n, o_done,
    input wire logic o_channel_request_n, o_host_address_gate
);
    default clocking @(posedge i_clock); endclocking
    default disable iff (i_reset);
    wire logic q = i_valid_address_strobe & o_phase2
        & (i_cpu_addr[14:12] == 3'h0);
    wire logic [3:0] sec = i_cpu_addr[11:8];
    property p_vma; !i_valid_address_strobe |-> o_ram_sel_n; endproperty
    a_vma: assert property (p_vma) else $error("ram select w/o vma");
    property p_ram; o_ram_sel_n == !(q && sec <= 4'h1); endproperty
    a_ram: assert property (p_ram) else $error("ram select wrong");
    property p_pia; o_pia_sel_n[5] == !(q && sec == 4'h7); endproperty
    a_pia: assert property (p_pia) else $error("adapter select");
    property p_bank;
        o_prom_bank_group_enables == (4'h1 << sec[3:2]);
    endproperty
    a_bank: assert property (p_bank) else $error("bank group");
    property p_nmi;
        $fell(i_nmi_source_n) |=> o_nmi_request ##1 !o_nmi_request;
    endproperty
    a_nmi: assert property (p_nmi) else $error("nmi pulse");
    property p_irq; o_irq_request == !i_irq_source_n; endproperty
    a_irq: assert property (p_irq) else $error("irq level");
    property p_oe; o_out_enable == (i_talk && i_atn_n); endproperty
    a_oe: assert property (p_oe) else $error("out enable");
    property p_atn; !i_atn_n |-> !o_nrfd_out && !o_nrfd_oe_n; endproperty
    a_atn: assert property (p_atn) else $error("nrfd on atn");
    property p_clr; i_clear |=> !o_done && o_channel_request_n; endproperty
    a_clr: assert property (p_clr) else $error("clear ignored");
    property p_mst;
        $rose(o_host_address_gate) |-> $past(i_sync_ack_n)
            && !$past(i_bus_busy);
    endproperty
    a_mst: assert property (p_mst) else $error("master too soon");
    c_nmi: cover property (o_nmi_request);
    c_done: cover property ($rose(o_done));
    c_ram: cover property (!o_ram_sel_n);
endmodule // sbg_glue_asserts
bind sbg_glue sbg_glue_asserts u_chk (.*);

/* tb/sbg_bus_model.sv */
`timescale 1ns/1ps
module sbg_bus_model (
    // from the glue
    input wire logic i_clock,
    input wire logic i_channel_request_n,
    input wire logic i_select_ack_n,
    input wire logic i_host_address_gate,
    // bench controls
    input wire logic [3:0] i_delay,
    input wire logic [15:0] i_word,
    // back to the glue
    output logic o_grant,
    output logic o_sync_ack_n,
    output logic [15:0] o_bus_data_n
);
    int cnt = 0;
    initial o_grant = 1'b0;
    initial o_sync_ack_n = 1'b1;
    always @(negedge i_clock) begin
        o_grant <= !i_channel_request_n && i_select_ack_n;
        cnt <= i_host_address_gate ? cnt + 1 : 0;
        o_sync_ack_n <= !(i_host_address_gate && cnt == i_delay);
    end
    // pulled-up bus reads all ones when not addressed
    assign o_bus_data_n = i_host_address_gate ? ~i_word : 16'hFFFF;
endmodule // sbg_bus_model

/* tb/sbg_glue_tb.sv */
`timescale 1ns/1ps
module sbg_glue_tb;
    logic i_clock = 0, i_reset = 1, valid_address_strobe = 0, rnw = 0, nmi_n = 1, irq_n = 1;
    logic talk = 0, listen = 0, rdy = 0, rfd = 0, atn_n = 1, dav_n = 1;
    logic clr = 0, hrd = 0, start = 0, strobe_n = 1, busy = 0, q;
    logic [15:0] addr = 16'h0000, word = 16'h0000, wdat = 16'h0000;
    logic [12:0] wadr = 13'h0000, badr_n;
    logic [3:0] dly = 4'h2, bank;
    logic p2, ram_n, oe, nrfd, nrfd_oe_n, done, scope_interrupt_line, req_n, ack_n, ag;
    logic grant, sync_n, nmi, irq;
    logic [5:0] pia_n, ep;
    logic [15:0] rd, bus_in_n, bus_out_n;
    int fails = 0, checked = 0, k, e;
    sbg_glue uut (.i_clock(i_clock), .i_reset(i_reset), .i_cpu_addr(addr),
        .i_valid_address_strobe(valid_address_strobe), .i_cpu_read_not_write(rnw),
        .i_nmi_source_n(nmi_n), .i_irq_source_n(irq_n), .o_phase1(),
        .o_phase2(p2), .o_cpu_bus_drive_enable(), .o_nmi_request(nmi),
        .o_irq_request(irq), .o_ram_sel_n(ram_n), .o_ram_write(),
        .o_adapter_read(), .o_pia_sel_n(pia_n), .o_prom_sel_n(),
        .o_prom_bank_group_enables(bank), .i_talk(talk), .i_listen(listen),
        .i_rdy(rdy), .i_rfd(rfd), .i_atn_n(atn_n), .i_dav_n(dav_n),
        .o_out_enable(oe), .o_nrfd_out(nrfd), .o_nrfd_oe_n(nrfd_oe_n),
        .o_ndac_out(), .o_ndac_oe_n(), .i_clear(clr), .i_host_read(hrd),
        .i_start(start), .i_wr_data(wdat), .i_wr_addr(wadr), .o_done(done),
        .o_scope_interrupt_line(scope_interrupt_line), .o_rd_data(rd),
        .i_bus_data_n(bus_in_n), .i_io_strobe_n(strobe_n),
        .i_priority_grant_input(grant), .i_sync_ack_n(sync_n),
        .i_bus_busy(busy), .o_channel_request_n(req_n),
        .o_select_ack_n(ack_n), .o_read_data(), .o_host_data_gate(),
        .o_host_address_gate(ag), .o_data_mode_n(),
        .o_bus_data_n(bus_out_n), .o_bus_addr_n(badr_n));
    sbg_bus_model far (.i_clock(i_clock), .i_channel_request_n(req_n),
        .i_select_ack_n(ack_n), .i_host_address_gate(ag), .i_delay(dly),
        .i_word(word), .o_grant(grant), .o_sync_ack_n(sync_n),
        .o_bus_data_n(bus_in_n));
    initial forever #25 i_clock = ~i_clock;
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        checked++;
        if (got !== exp) begin
            fails++;
            $display("BAD t=%0t got %h want %h", $time, got, exp);
        end
    endtask
    task automatic give_verdict;
        $display("checked %0d fails %0d", checked, fails);
        if (fails == 0 && checked > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask
    // slow far side also holds busy, so mastering must wait
    task automatic xfer(input logic op, input logic [3:0] d);
        @(negedge i_clock);
        clr = 1;
        dly = d;
        hrd = op;
        busy = d > 4'h2;
        word = 16'($urandom);
        wdat = 16'($urandom);
        wadr = 13'($urandom);
        @(negedge i_clock);
        clr = 0;
        @(negedge i_clock);
        start = 1;
        for (k = 0; k < 60 && done !== 1'b1; k++) begin
            @(negedge i_clock);
            if (busy) chk(ag, 1'b0);
            if (k == 4) busy = 0;
            if (ag === 1'b1) chk({3'h0, badr_n}, {3'h0, ~wadr});
            if (ag === 1'b1) chk(bus_out_n, op ? 16'hFFFF : ~wdat);
        end
        if (done !== 1'b1) begin
            fails++;
            give_verdict;
        end
        if (op) chk(rd, word);
        start = 0;
        repeat (2) @(negedge i_clock);
        start = 1;
        repeat (3) @(negedge i_clock);
        chk({req_n, done}, 2'b11);
        start = 0;
    endtask
    initial begin
        k = $urandom(62900);
        repeat (20) @(negedge i_clock);
        i_reset = 0;
        for (e = 0; e < 300; e++) begin
            @(negedge i_clock);
            {valid_address_strobe, rnw, irq_n, talk, atn_n, listen, rdy, rfd, dav_n} =
                9'($urandom);
            addr = 16'($urandom);
            #1;
            q = valid_address_strobe && p2 && addr[14:12] == 3'h0;
            for (k = 0; k < 6; k++) ep[k] = !(q && addr[11:8] == k + 2);
            chk(ram_n, !(q && addr[11:8] < 4'h2));
            chk(pia_n, ep);
            chk(bank, 4'h1 << addr[11:10]);
            chk(oe, talk && atn_n);
            chk(irq, !irq_n);
            chk(nrfd_oe_n ? 1'b1 : nrfd, !((listen && !rdy) ||
                (talk && !rfd) || !atn_n));
        end
        atn_n = 1;
        xfer(1'b1, 4'h2);
        xfer(1'b0, 4'h2);
        xfer(1'b1, 4'h9);
        xfer(1'b0, 4'h9);
        @(negedge i_clock);
        strobe_n = 0;
        nmi_n = 0;
        @(negedge i_clock);
        strobe_n = 1;
        chk(nmi, 1'b1);
        repeat (4) @(negedge i_clock);
        chk(nmi, 1'b0);
        chk(scope_interrupt_line, 1'b1);
        clr = 1;
        nmi_n = 1;
        @(negedge i_clock);
        clr = 0;
        chk(scope_interrupt_line, 1'b0);
        give_verdict;
    end
endmodule // sbg_glue_tb
